// *** hdl/smb_port_cfg.sv ***
/*
 Configuration and status block for the second two-wire port: AXI4-Lite
 register slave, bus monitor (busy, start/stop, free timeout), clock-low
 timeout timer steering, bit-rate source select and interrupt logic.
 Assumes timer overflows arrive as one-cycle pulses on clock_in and the
 bus lines arrive asynchronously.
*/
// The AXI4-Lite register port was chosen for this implementation.
// What this block does
// - While enabled the port watches both bus lines, and while disabled it is idle.
// - With slave inhibit set no slave event raises an interrupt, but master events still do.
// - The busy flag is set by hardware while a transfer runs on the bus.
// - The busy flag clears on a stop condition or on bus-free timeout expiry.
// - The hold extension bit picks normal or extended data setup and hold time.
// - With clock-low timeout on, the timer is held in reload while clock is high and counts while low.
// - In split mode only the timer high byte is held in reload while clock is high.
// - With free timeout on, both lines high for over 10 bit-rate periods means the bus is free.
// - The two-bit source field selects timer 0, timer 5, timer 2 high or timer 2 low overflow.
module smb_port_cfg
#(
    parameter int unsigned FREE_COUNT = smb_cfg_pkg::FREE_PERIODS
)
(
    input  wire logic                   clock_in,
    input  wire logic                   arst_n_in,
    input  wire logic [11:0]            s_axi_awaddr_in,
    input  wire logic                   s_axi_awvalid_in,
    output logic                        s_axi_awready_out,
    input  wire logic [31:0]            s_axi_wdata_in,
    input  wire logic [3:0]             s_axi_wstrb_in,
    input  wire logic                   s_axi_wvalid_in,
    output logic                        s_axi_wready_out,
    output logic [1:0]                  s_axi_bresp_out,
    output logic                        s_axi_bvalid_out,
    input  wire logic                   s_axi_bready_in,
    input  wire logic [11:0]            s_axi_araddr_in,
    input  wire logic                   s_axi_arvalid_in,
    output logic                        s_axi_arready_out,
    output logic [31:0]                 s_axi_rdata_out,
    output logic [1:0]                  s_axi_rresp_out,
    output logic                        s_axi_rvalid_out,
    input  wire logic                   s_axi_rready_in,
    input  wire logic                   data_line_in,
    input  wire logic                   clock_line_in,
    input  wire smb_cfg_pkg::overflow_s overflow_in,
    input  wire logic                   slave_event_in,
    input  wire logic                   master_event_in,
    output smb_cfg_pkg::reload_s        reload_out,
    output logic                        bit_tick_out,
    output logic [7:0]                  hold_cycles_out,
    output logic                        port_active_out,
    output logic                        event_irq_out,
    output logic                        irq_out
);
    import smb_cfg_pkg::*;

    logic [7:0]       cfg;
    logic             split_mode;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic             busy;
    logic [7:0]       free_cnt;
    logic             sda;
    logic             scl;
    logic             sda_rise;
    logic             sda_fall;
    logic             scl_rise;
    logic             scl_fall;
    logic             tick;
    logic             start_det;
    logic             stop_det;
    logic             free_expire;
    logic [11:0]      aw_addr;
    logic             aw_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             w_held;
    logic             wr_fire;
    logic             wr_cfg;
    logic             wr_status;
    logic             wr_mask;
    logic             wr_timer;
    logic [IRQ_W-1:0] events;
    logic [31:0]      next_rdata;
    logic [1:0]       next_rresp;

    // Both lines pass two flops before anything reads them
    line_sync u_sda
    (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .line_in   (data_line_in),
        .level_out (sda),
        .rise_out  (sda_rise),
        .fall_out  (sda_fall)
    );

    line_sync u_scl
    (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .line_in   (clock_line_in),
        .level_out (scl),
        .rise_out  (scl_rise),
        .fall_out  (scl_fall)
    );

    // Bit-rate time base from the selected overflow pulse
    always_comb
    begin
        case (rate_src_e'(cfg[SRC_HI:SRC_LO]))
            SRC_TIMER0:    tick = overflow_in.timer0;
            SRC_TIMER5:    tick = overflow_in.timer5;
            SRC_TIMER2_HI: tick = overflow_in.timer2_hi;
            SRC_TIMER2_LO: tick = overflow_in.timer2_lo;
            default:       tick = 1'b0;
        endcase
    end

    // Conditions are only seen while the port is enabled
    assign start_det = cfg[ENABLE_BIT] & scl & sda_fall;
    assign stop_det  = cfg[ENABLE_BIT] & scl & sda_rise;

    // Free timeout counter, cleared whenever a line is low
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            free_cnt <= 8'h00;
        else if (!cfg[ENABLE_BIT] || !cfg[FREE_TO_BIT] || !sda || !scl || !busy)
            free_cnt <= 8'h00;
        else if (tick && free_cnt <= 8'(FREE_COUNT))
            free_cnt <= free_cnt + 8'h01;
    end

    // More than the count: expire on the period after the tenth
    assign free_expire = busy && sda && scl && cfg[FREE_TO_BIT] && tick && (free_cnt == 8'(FREE_COUNT));

    // Busy flag: start or clock-line fall sets, stop or free timeout clears, set wins
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            busy <= 1'b0;
        else if (!cfg[ENABLE_BIT])
            busy <= 1'b0;
        else if (start_det || scl_fall)
            busy <= 1'b1;
        else if (stop_det || free_expire)
            busy <= 1'b0;
    end

    // Timer reload steering follows the synchronised clock line
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            reload_out <= '0;
        else
        begin
            reload_out.reload_high <= cfg[ENABLE_BIT] & cfg[LOW_TO_BIT] & scl;
            reload_out.reload_low  <= cfg[ENABLE_BIT] & cfg[LOW_TO_BIT] & scl & ~split_mode;
        end
    end

    // Registered copies of tick, hold time and enable
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            bit_tick_out    <= 1'b0;
            hold_cycles_out <= 8'(HOLD_NORMAL_CYC);
            port_active_out <= 1'b0;
        end
        else
        begin
            bit_tick_out    <= tick & cfg[ENABLE_BIT];
            hold_cycles_out <= cfg[HOLD_EXT_BIT] ? 8'(HOLD_EXTENDED_CYC) : 8'(HOLD_NORMAL_CYC);
            port_active_out <= cfg[ENABLE_BIT];
        end
    end

    // Slave interrupt gated by inhibit; master events pass untouched
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            event_irq_out <= 1'b0;
        else
            event_irq_out <= cfg[ENABLE_BIT] & (master_event_in | (slave_event_in & ~cfg[INHIBIT_BIT]));
    end

    // Event vector into sticky status
    always_comb
    begin
        events                = '0;
        events[IRQ_START_BIT] = start_det;
        events[IRQ_STOP_BIT]  = stop_det;
        events[IRQ_FREE_BIT]  = free_expire;
        events[IRQ_SLAVE_BIT] = cfg[ENABLE_BIT] & slave_event_in & ~cfg[INHIBIT_BIT];
    end

    // Write channel capture; address and data may come in either order
    assign wr_fire   = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_cfg    = wr_fire && aw_addr == CFG_ADDR && w_strb[0];
    assign wr_status = wr_fire && aw_addr == IRQ_STATUS_ADDR && w_strb[0];
    assign wr_mask   = wr_fire && aw_addr == IRQ_MASK_ADDR && w_strb[0];
    assign wr_timer  = wr_fire && aw_addr == TIMER_CTRL_ADDR && w_strb[0];

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            aw_held           <= 1'b0;
            aw_addr           <= 12'h000;
            s_axi_awready_out <= 1'b0;
        end
        else
        begin
            s_axi_awready_out <= !aw_held && !s_axi_awready_out && s_axi_awvalid_in;
            if (s_axi_awready_out && s_axi_awvalid_in)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            w_held           <= 1'b0;
            w_data           <= 32'h0000_0000;
            w_strb           <= 4'h0;
            s_axi_wready_out <= 1'b0;
        end
        else
        begin
            s_axi_wready_out <= !w_held && !s_axi_wready_out && s_axi_wvalid_in;
            if (s_axi_wready_out && s_axi_wvalid_in)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (aw_addr == CFG_ADDR || aw_addr == IRQ_STATUS_ADDR ||
                                 aw_addr == IRQ_MASK_ADDR || aw_addr == TIMER_CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
    end

    // Software-writable config bits; busy bit is read-only
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg        <= CFG_RESET;
            split_mode <= 1'b0;
            irq_mask   <= IRQ_RESET;
        end
        else
        begin
            if (wr_cfg)
                cfg <= w_data[7:0] & CFG_WRITE_MASK;
            if (wr_timer)
                split_mode <= w_data[SPLIT_BIT];
            if (wr_mask)
                irq_mask <= w_data[IRQ_W-1:0];
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            irq_status <= IRQ_RESET;
        else
            irq_status <= (irq_status & ~(wr_status ? w_data[IRQ_W-1:0] : '0)) | events;
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(irq_status & irq_mask);
    end

    // Read mux; busy bit shows live hardware state
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        case (s_axi_araddr_in)
            CFG_ADDR:
            begin
                next_rdata[7:0]      = cfg;
                next_rdata[BUSY_BIT] = busy;
            end
            IRQ_STATUS_ADDR: next_rdata[IRQ_W-1:0]   = irq_status;
            IRQ_MASK_ADDR:   next_rdata[IRQ_W-1:0]   = irq_mask;
            TIMER_CTRL_ADDR: next_rdata[SPLIT_BIT]   = split_mode;
            default:         next_rresp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
            if (s_axi_arready_out && s_axi_arvalid_in)
            begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= next_rdata;
                s_axi_rresp_out  <= next_rresp;
            end
            else if (s_axi_rready_in)
                s_axi_rvalid_out <= 1'b0;
        end
    end

    // Multi-step checks
    sequence stop_seen;
        stop_det && !start_det && !scl_fall;
    endsequence

    chk_busy_stop_clear: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        stop_seen |=> !busy) else $error("busy not cleared after stop");
    chk_busy_start_set: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        start_det |=> busy) else $error("busy not set after start");
    chk_free_expiry: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        free_expire |=> !busy) else $error("busy kept after free timeout");
    chk_reload_high: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        ##1 reload_out.reload_high == $past(cfg[ENABLE_BIT] && cfg[LOW_TO_BIT] && scl))
        else $error("reload high mismatch");
    chk_split_reload: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $past(split_mode) |-> !reload_out.reload_low) else $error("low byte reloaded in split mode");
    chk_inhibit_slave: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        cfg[INHIBIT_BIT] && !master_event_in && !wr_cfg |=> !event_irq_out)
        else $error("slave interrupt while inhibited");
    chk_hold_select: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        cfg[HOLD_EXT_BIT] && !wr_cfg |=> hold_cycles_out == 8'(HOLD_EXTENDED_CYC))
        else $error("hold time not extended");
    chk_idle_disabled: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        !cfg[ENABLE_BIT] |=> !busy && !bit_tick_out) else $error("activity while disabled");
    chk_source_select: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        cfg[ENABLE_BIT] && cfg[SRC_HI:SRC_LO] == SRC_TIMER5 && !wr_cfg |=> bit_tick_out == $past(overflow_in.timer5))
        else $error("wrong bit-rate source");

endmodule // smb_port_cfg

// *** inc/smb_cfg_pkg.sv ***
/*
 Package for the second two-wire port configuration block: register map,
 field positions, reset values, interrupt layout, timing constants.
 Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package smb_cfg_pkg;

    // Register byte addresses (printed offset is an index, byte address is 4x)
    localparam int unsigned CFG_INDEX       = 32'h0000_00c1;
    localparam logic [11:0] CFG_ADDR        = 12'(CFG_INDEX * 4);
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h000;
    localparam logic [11:0] IRQ_MASK_ADDR   = 12'h004;
    localparam logic [11:0] TIMER_CTRL_ADDR = 12'h008;

    // Configuration register fields
    localparam int ENABLE_BIT   = 7;
    localparam int INHIBIT_BIT  = 6;
    localparam int BUSY_BIT     = 5;
    localparam int HOLD_EXT_BIT = 4;
    localparam int LOW_TO_BIT   = 3;
    localparam int FREE_TO_BIT  = 2;
    localparam int SRC_HI       = 1;
    localparam int SRC_LO       = 0;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hdf;

    // Timer control register: split mode flag of the timeout timer
    localparam int SPLIT_BIT = 0;

    // Interrupt status and mask layout
    localparam int IRQ_W          = 4;
    localparam int IRQ_START_BIT  = 0;
    localparam int IRQ_STOP_BIT   = 1;
    localparam int IRQ_FREE_BIT   = 2;
    localparam int IRQ_SLAVE_BIT  = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // Free timeout: more than this many bit-rate periods with both lines high
    localparam int unsigned FREE_PERIODS = 10;

    // Setup/hold extension figures in system clocks
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned HOLD_NORMAL_NS   = 15;
    localparam int unsigned HOLD_EXTENDED_NS = 60;
    localparam int unsigned HOLD_NORMAL_CYC   = (HOLD_NORMAL_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_EXTENDED_CYC = (HOLD_EXTENDED_NS * CLK_MHZ + 999) / 1000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Bit-rate source encodings
    typedef enum logic [1:0] {
        SRC_TIMER0    = 2'b00,
        SRC_TIMER5    = 2'b01,
        SRC_TIMER2_HI = 2'b10,
        SRC_TIMER2_LO = 2'b11
    } rate_src_e;

    // Timer overflow pulses offered as bit-rate sources
    typedef struct packed {
        logic timer2_lo;
        logic timer2_hi;
        logic timer5;
        logic timer0;
    } overflow_s;

    // Reload request toward the timeout timer
    typedef struct packed {
        logic reload_high;
        logic reload_low;
    } reload_s;

endpackage

// *** hdl/line_sync.sv ***
/*
 Two-flop synchroniser with registered edge detection for one bus line.
 Assumes the line is asynchronous to clock_in; the first flop feeds only
 the second.
*/
module line_sync
(
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    input  wire logic line_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta;
    logic prev;

    // Idle bus is high, so flops reset to one
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta      <= 1'b1;
            level_out <= 1'b1;
            prev      <= 1'b1;
        end
        else
        begin
            meta      <= line_in;
            level_out <= meta;
            prev      <= level_out;
        end
    end

    // Edges compare synchronised level against its previous value
    assign rise_out = level_out & ~prev;
    assign fall_out = ~level_out & prev;

endmodule // line_sync

// *** verification/two_wire_peer.sv ***
/*
 Behavioural two-wire bus peer acting as an outside master.
 Assumes pull-ups, so released lines read high; the link clock stands
 high between frames.
*/
module two_wire_peer
(
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int half_ns = 32; // 64 ns link clock; slow peers just raise this

    // Idle bus from time zero
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // Start: data falls while clock is high
    task automatic start_frame();
        #1 sda_out = 1'b0;
        #(half_ns) scl_out = 1'b0;
        #(half_ns);
    endtask

    // One bit; data moves only while the clock is low
    task automatic put_bit(input logic b);
        sda_out = b;
        #(half_ns) scl_out = 1'b1;
        #(half_ns) scl_out = 1'b0;
    endtask

    // Stop: data rises while clock is high
    task automatic stop_frame();
        #1 sda_out = 1'b0;
        #(half_ns) scl_out = 1'b1;
        #(half_ns) sda_out = 1'b1;
        #(half_ns);
    endtask

    // Let go of both lines without a stop, so the bus stays busy
    task automatic release_lines();
        sda_out = 1'b1;
        #(half_ns) scl_out = 1'b1;
        #(half_ns);
    endtask
endmodule // two_wire_peer

// *** verification/test_smb_port_cfg.sv ***
/*
 Self-checking bench for smb_port_cfg: AXI4-Lite master tasks, a register
 model, timer overflow and event stimulus, and the two-wire peer.
 Assumes the package and the peer model are compiled first.
*/
module test_smb_port_cfg;
    timeunit 1ns;
    timeprecision 100ps;
    import smb_cfg_pkg::*;

    localparam int unsigned FREE_SMALL = 2; // Short free timeout keeps runs brief
    logic        clock_in = 1'b0, arst_n_in = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    overflow_s   overflow = '0;
    logic        slave_ev = 1'b0, master_ev = 1'b0;
    reload_s     reload;
    logic        tick, active, ev_irq, irq, scl, sda;
    logic [7:0]  hold_cyc;
    int          err_count = 0, check_count = 0, seed = 454;
    int          cfg_m = 0, stat_m = 0;

    // 200 MHz system clock
    always #2.5 clock_in = ~clock_in;

    smb_port_cfg #(.FREE_COUNT(FREE_SMALL)) dut_u
    (
        .clock_in(clock_in), .arst_n_in(arst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .data_line_in(sda), .clock_line_in(scl), .overflow_in(overflow),
        .slave_event_in(slave_ev), .master_event_in(master_ev), .reload_out(reload),
        .bit_tick_out(tick), .hold_cycles_out(hold_cyc), .port_active_out(active),
        .event_irq_out(ev_irq), .irq_out(irq)
    );

    two_wire_peer peer_u (.scl_out(scl), .sda_out(sda));

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        @(posedge clock_in);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clock_in);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (n == 100)
            err_count++;
        check("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        int n;
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clock_in);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        if (n == 100)
            err_count++;
        check(what, rdata, exp);
        check("rresp", 32'(rresp), 32'(er));
    endtask

    // Model write of the config register, then let registered outputs follow
    task automatic set_cfg(input int v);
        cfg_m = v & 32'h0000_00ff;
        axi_wr(CFG_ADDR, 32'(v), 4'hf, RESP_OKAY);
        repeat (2) @(posedge clock_in);
    endtask

    // One-cycle overflow and event pulses; returns once their result is settled
    task automatic pulse(input logic [3:0] ov, input logic sl, input logic ms);
        @(posedge clock_in);
        overflow <= overflow_s'(ov);
        slave_ev <= sl;
        master_ev <= ms;
        @(posedge clock_in);
        overflow <= '0;
        slave_ev <= 1'b0;
        master_ev <= 1'b0;
        #1;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #300000;
        err_count++;
        end_sim();
    end

    // Test sequence
    initial
    begin
        int v;
        repeat (5) @(posedge clock_in);
        arst_n_in <= 1'b1;
        check("hold reset", 32'(hold_cyc), HOLD_NORMAL_CYC);
        check("active reset", 32'(active), 32'h0000_0000);
        rd_chk("cfg reset", CFG_ADDR, 32'(CFG_RESET), RESP_OKAY);
        rd_chk("status reset", IRQ_STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
        rd_chk("mask reset", IRQ_MASK_ADDR, 32'h0000_0000, RESP_OKAY);
        rd_chk("unmapped", 12'h100, 32'h0000_0000, RESP_SLVERR);
        axi_wr(12'h100, 32'h0000_00ff, 4'hf, RESP_SLVERR);
        $display("test reset done");

        // Random configs; busy stays clear on an idle bus
        repeat (4)
        begin
            v = $random(seed);
            set_cfg(v);
            rd_chk("cfg", CFG_ADDR, 32'(cfg_m & CFG_WRITE_MASK), RESP_OKAY);
            check("hold", 32'(hold_cyc), cfg_m[4] ? HOLD_EXTENDED_CYC : HOLD_NORMAL_CYC);
            check("active", 32'(active), 32'(cfg_m[7]));
        end
        axi_wr(CFG_ADDR, 32'h0000_00ff, 4'h0, RESP_OKAY);
        rd_chk("cfg no strobe", CFG_ADDR, 32'(cfg_m & CFG_WRITE_MASK), RESP_OKAY);
        $display("test config done");

        // Every source code against every overflow, then disabled
        for (int s = 0; s < 4; s++)
        begin
            set_cfg(32'h0000_0080 | s);
            for (int i = 0; i < 4; i++)
            begin
                pulse(4'(1 << i), 1'b0, 1'b0);
                check("tick", 32'(tick), 32'(i == s));
            end
        end
        set_cfg(32'h0000_0000);
        pulse(4'hf, 1'b0, 1'b0);
        check("tick off", 32'(tick), 32'h0000_0000);
        $display("test source done");

        // Slave events silenced by inhibit, master events never
        for (int h = 0; h < 2; h++)
        begin
            set_cfg(32'h0000_0080 | (h << INHIBIT_BIT));
            pulse(4'h0, 1'b1, 1'b0);
            check("slave irq", 32'(ev_irq), 32'(h == 0));
            pulse(4'h0, 1'b0, 1'b1);
            check("master irq", 32'(ev_irq), 32'h0000_0001);
        end
        stat_m = 1 << IRQ_SLAVE_BIT;
        rd_chk("status slave", IRQ_STATUS_ADDR, 32'(stat_m), RESP_OKAY);
        $display("test events done");

        // Start sets busy, stop clears it; status, mask and W1C
        set_cfg(32'h0000_0080);
        axi_wr(IRQ_STATUS_ADDR, 32'h0000_000f, 4'hf, RESP_OKAY);
        peer_u.start_frame();
        peer_u.put_bit(1'b1);
        rd_chk("busy set", CFG_ADDR, 32'h0000_00a0, RESP_OKAY);
        rd_chk("status start", IRQ_STATUS_ADDR, 32'h0000_0001, RESP_OKAY);
        check("irq masked", 32'(irq), 32'h0000_0000);
        axi_wr(IRQ_MASK_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
        repeat (2) @(posedge clock_in);
        check("irq up", 32'(irq), 32'h0000_0001);
        peer_u.stop_frame();
        rd_chk("busy stop", CFG_ADDR, 32'h0000_0080, RESP_OKAY);
        axi_wr(IRQ_STATUS_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
        repeat (2) @(posedge clock_in);
        check("irq cleared", 32'(irq), 32'h0000_0000);
        rd_chk("status stop", IRQ_STATUS_ADDR, 32'h0000_0002, RESP_OKAY);
        $display("test busy done");

        // Free timeout: bus left high without a stop
        set_cfg(32'h0000_0084);
        axi_wr(IRQ_STATUS_ADDR, 32'h0000_000f, 4'hf, RESP_OKAY);
        peer_u.start_frame();
        peer_u.put_bit(1'b0);
        peer_u.release_lines();
        repeat (FREE_SMALL) pulse(4'h1, 1'b0, 1'b0);
        rd_chk("free early", CFG_ADDR, 32'h0000_00a4, RESP_OKAY);
        pulse(4'h1, 1'b0, 1'b0);
        repeat (3) @(posedge clock_in);
        rd_chk("free done", CFG_ADDR, 32'h0000_0084, RESP_OKAY);
        rd_chk("status free", IRQ_STATUS_ADDR, 32'h0000_0005, RESP_OKAY);
        $display("test free done");

        // Timeout timer reload follows the clock line, split mode high byte only
        set_cfg(32'h0000_0098);
        check("reload full", 32'(reload), 32'h0000_0003);
        check("hold ext", 32'(hold_cyc), HOLD_EXTENDED_CYC);
        axi_wr(TIMER_CTRL_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
        repeat (2) @(posedge clock_in);
        check("reload split", 32'(reload), 32'h0000_0002);
        peer_u.start_frame();
        check("reload low", 32'(reload), 32'h0000_0000);
        // Timeout handler restarts the port
        set_cfg(32'h0000_0018);
        set_cfg(32'h0000_0098);
        rd_chk("busy restart", CFG_ADDR, 32'h0000_0098, RESP_OKAY);
        peer_u.stop_frame();
        $display("test reload done");
        end_sim();
    end
endmodule // test_smb_port_cfg
